// file: logic/bool_proc_consts.vh
/*
 * Constants for the single-bit Boolean datapath: operation codes,
 * bit addresses, status-word field positions and cycle counts.
 * Assumes inclusion by bare name from the datapath module only.
 */
`ifndef BOOL_PROC_CONSTS_VH
`define BOOL_PROC_CONSTS_VH

// ============================================================
// Operation codes issued by the instruction decoder
`define OP_NONE        4'h0
`define OP_MOVE_TO_C   4'h1
`define OP_MOVE_FROM_C 4'h2
`define OP_AND_C       4'h3
`define OP_OR_C        4'h4
`define OP_JMP_C_SET   4'h5
`define OP_JMP_C_CLR   4'h6
`define OP_JMP_B_SET   4'h7
`define OP_JMP_B_CLR   4'h8
`define OP_JMP_B_CLEAR 4'h9
`define OP_SHORT_JMP   4'hA
`define OP_SET_C       4'hB
`define OP_CLR_C       4'hC
`define OP_SET_BIT     4'hD
`define OP_CLR_BIT     4'hE

// ============================================================
// Bit addresses and status-word layout
`define STATUS_BIT_BASE  8'hD0
`define USER_FLAG0_ADDR  8'hD5
`define USER_FLAG0_POS   5
`define CARRY_POS        7
`define STATUS_RESET     8'h00

// ============================================================
// Machine cycles per operation
`define CYC_SHORT        2'h1
`define CYC_LONG         2'h2

`endif

// file: logic/bool_bit_proc.v
/*
 * Single-bit Boolean datapath of an 8-bit core: carry flag, bit moves,
 * AND/OR with carry, bit and carry conditional relative jumps.
 * Assumes the decoder issues one op pulse per instruction with its
 * operands stable, the bit store answers reads combinationally and
 * takes writes on the clock, and the program counter logic holds off
 * the next op until DONE_OUT. One clock edge is one machine cycle.
 */
`include "bool_proc_consts.vh"

// Functional notes
// - Any bit reached by 8-bit address 0-255
// - Address 0D5H is status word bit 5
// - Load carry from bit in one cycle
// - Store carry into bit, two cycles
// - AND/OR carry with bit or complement
// - Complemented source bit stays unchanged
// - Carry jumps branch on one or zero
// - Bit jumps test any bit, three bytes
// - Jump-and-clear clears bit, two cycles
// - Conditional jumps relative, always two cycles
// - Signed displacement added to incremented PC
// - Zero displacement targets next instruction
// - Short jump uses same relative arithmetic
// - Rotate and arithmetic also update carry
module bool_bit_proc (
    // Clock and reset
    input  wire        MCLK_IN,
    input  wire        RST_IN,
    // Decoder request
    input  wire        OP_VALID_IN,
    input  wire [3:0]  OP_CODE_IN,
    input  wire [7:0]  BIT_ADDR_IN,
    input  wire        BIT_INV_IN,
    input  wire [7:0]  DISP_IN,
    input  wire [15:0] PC_NEXT_IN,
    // Bit store read port
    input  wire        BIT_RDATA_IN,
    // Carry updates from rotate and arithmetic
    input  wire        ALU_C_WE_IN,
    input  wire        ALU_C_IN,
    // Bit store write port
    output reg  [7:0]  BIT_ADDR_OUT,
    output reg         BIT_WE_OUT,
    output reg         BIT_WDATA_OUT,
    // Program counter redirect
    output reg         JUMP_OUT,
    output reg  [15:0] JUMP_TARGET_OUT,
    // Status
    output wire        DONE_OUT,
    output wire        BUSY_OUT,
    output wire        CARRY_OUT,
    output wire [7:0]  STATUS_OUT
);

    // ============================================================
    // State
    localparam ST_IDLE = 1'b0;  // Ready for an op
    localparam ST_SEC  = 1'b1;  // Second machine cycle

    reg         state_reg;       // Sequencer state
    reg         state_next;
    reg  [7:0]  status_reg;      // Status word, carry in bit 7
    reg  [7:0]  status_next;
    reg         done_reg;        // One-cycle completion pulse
    reg         done_next;
    reg  [7:0]  addr_reg;        // Latched bit address
    reg         wval_reg;        // Latched value for second-cycle write
    reg         wen_reg;         // Second-cycle write wanted
    reg         take_reg;        // Branch decision
    reg  [15:0] tgt_reg;         // Branch target
    reg  [7:0]  bit_addr_next;
    reg         bit_we_next;
    reg         bit_wdata_next;
    reg         jump_next;

    // ============================================================
    // Helpers
    // Base of the eight status-word bit addresses, sized for slicing
    localparam [7:0] STATUS_BASE = `STATUS_BIT_BASE;

    // Status word bits live here; everything else is external storage
    function is_status;
        input [7:0] a;
        begin
            is_status = (a[7:3] == STATUS_BASE[7:3]);
        end
    endfunction

    // Sign-extend displacement and add to the incremented PC
    function [15:0] rel_target;
        input [15:0] pc;
        input [7:0]  d;
        begin
            rel_target = pc + {{8{d[7]}}, d};
        end
    endfunction

    // Bit value seen at an address, status word served locally
    wire        src_bit = is_status(BIT_ADDR_IN) ?
                          status_reg[BIT_ADDR_IN[2:0]] : BIT_RDATA_IN;
    wire        opr_bit = src_bit ^ BIT_INV_IN;  // Operand only
    wire        carry   = status_reg[`CARRY_POS];
    wire        start   = OP_VALID_IN && (state_reg == ST_IDLE);

    assign DONE_OUT   = done_reg;
    assign BUSY_OUT   = (state_reg == ST_SEC);
    assign CARRY_OUT  = carry;
    assign STATUS_OUT = status_reg;

    // ============================================================
    // Next-state and datapath
    always @* begin
        state_next     = state_reg;
        status_next    = status_reg;
        done_next      = 1'b0;
        bit_addr_next  = BIT_ADDR_OUT;
        bit_we_next    = 1'b0;
        bit_wdata_next = BIT_WDATA_OUT;
        jump_next      = 1'b0;
        // Rotates and arithmetic write the carry directly
        if (ALU_C_WE_IN) begin
            status_next[`CARRY_POS] = ALU_C_IN;
        end
        case (state_reg)
            ST_IDLE: begin
                if (start) begin
                    case (OP_CODE_IN)
                        `OP_MOVE_TO_C: begin
                            // Single cycle, done right away
                            status_next[`CARRY_POS] = src_bit;
                            done_next = 1'b1;
                        end
                        `OP_AND_C: begin
                            status_next[`CARRY_POS] = carry & opr_bit;
                            done_next = 1'b1;
                        end
                        `OP_OR_C: begin
                            status_next[`CARRY_POS] = carry | opr_bit;
                            done_next = 1'b1;
                        end
                        `OP_SET_C: begin
                            status_next[`CARRY_POS] = 1'b1;
                            done_next = 1'b1;
                        end
                        `OP_CLR_C: begin
                            status_next[`CARRY_POS] = 1'b0;
                            done_next = 1'b1;
                        end
                        `OP_SET_BIT, `OP_CLR_BIT: begin
                            // Single-cycle bit write
                            if (is_status(BIT_ADDR_IN)) begin
                                status_next[BIT_ADDR_IN[2:0]] =
                                    (OP_CODE_IN == `OP_SET_BIT);
                            end else begin
                                bit_we_next    = 1'b1;
                                bit_addr_next  = BIT_ADDR_IN;
                                bit_wdata_next = (OP_CODE_IN == `OP_SET_BIT);
                            end
                            done_next = 1'b1;
                        end
                        `OP_NONE: begin
                            done_next = 1'b1;
                        end
                        default: begin
                            // Two-cycle ops finish in ST_SEC
                            state_next = ST_SEC;
                        end
                    endcase
                end
            end
            ST_SEC: begin
                // Second cycle: write back and redirect
                if (wen_reg) begin
                    if (is_status(addr_reg)) begin
                        status_next[addr_reg[2:0]] = wval_reg;
                    end else begin
                        bit_we_next    = 1'b1;
                        bit_addr_next  = addr_reg;
                        bit_wdata_next = wval_reg;
                    end
                end
                jump_next  = take_reg;
                done_next  = 1'b1;
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ============================================================
    // First-cycle capture of branch decision and write-back
    reg take_now;
    always @* begin
        take_now = 1'b0;
        case (OP_CODE_IN)
            `OP_JMP_C_SET:   take_now = carry;
            `OP_JMP_C_CLR:   take_now = ~carry;
            `OP_JMP_B_SET:   take_now = src_bit;
            `OP_JMP_B_CLR:   take_now = ~src_bit;
            `OP_JMP_B_CLEAR: take_now = src_bit;
            `OP_SHORT_JMP:   take_now = 1'b1;
            default:         take_now = 1'b0;
        endcase
    end

    // ============================================================
    // Registers
    always @(posedge MCLK_IN) begin
        if (RST_IN) begin
            state_reg       <= ST_IDLE;
            status_reg      <= `STATUS_RESET;
            done_reg        <= 1'b0;
            addr_reg        <= 8'h00;
            wval_reg        <= 1'b0;
            wen_reg         <= 1'b0;
            take_reg        <= 1'b0;
            tgt_reg         <= 16'h0000;
            BIT_ADDR_OUT    <= 8'h00;
            BIT_WE_OUT      <= 1'b0;
            BIT_WDATA_OUT   <= 1'b0;
            JUMP_OUT        <= 1'b0;
            JUMP_TARGET_OUT <= 16'h0000;
        end else begin
            state_reg     <= state_next;
            status_reg    <= status_next;
            done_reg      <= done_next;
            BIT_ADDR_OUT  <= bit_addr_next;
            BIT_WE_OUT    <= bit_we_next;
            BIT_WDATA_OUT <= bit_wdata_next;
            JUMP_OUT      <= jump_next;
            if (start) begin
                addr_reg <= BIT_ADDR_IN;
                take_reg <= take_now;
                tgt_reg  <= rel_target(PC_NEXT_IN, DISP_IN);
                // Store carry, or clear a set bit on taken branch
                wen_reg  <= (OP_CODE_IN == `OP_MOVE_FROM_C) ||
                            ((OP_CODE_IN == `OP_JMP_B_CLEAR) && src_bit);
                wval_reg <= (OP_CODE_IN == `OP_MOVE_FROM_C) ? carry : 1'b0;
            end
            if (jump_next) begin
                JUMP_TARGET_OUT <= tgt_reg;
            end
        end
    end

endmodule

// file: tb/bool_bit_chk_sva.sv
/* Assertions for the Boolean bit datapath, bound to its top module.
   Assumes operands hold still while an operation is in flight. */
module bool_bit_chk (
    input logic        MCLK_IN, RST_IN, OP_VALID_IN, BIT_INV_IN, BIT_RDATA_IN,
    input logic        ALU_C_WE_IN, ALU_C_IN, BIT_WE_OUT, BIT_WDATA_OUT,
    input logic        JUMP_OUT, DONE_OUT, BUSY_OUT, CARRY_OUT,
    input logic [3:0]  OP_CODE_IN,
    input logic [7:0]  BIT_ADDR_IN, DISP_IN, BIT_ADDR_OUT,
    input logic [15:0] PC_NEXT_IN, JUMP_TARGET_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // Op taken with no carry write racing it; ex also off the status word
    wire tk = OP_VALID_IN && !BUSY_OUT && !ALU_C_WE_IN;
    wire ex = tk && BIT_ADDR_IN[7:3] != 5'h1A;
    wire sb = BIT_RDATA_IN ^ BIT_INV_IN;
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (RST_IN);
    a_load_carry: assert property (ex && OP_CODE_IN == 4'h1 |=>
        DONE_OUT && CARRY_OUT == $past(BIT_RDATA_IN)) else $error("carry load");
    a_store_carry: assert property (ex && OP_CODE_IN == 4'h2 |=> BUSY_OUT ##1
        BIT_WE_OUT && BIT_WDATA_OUT == $past(CARRY_OUT, 2)
        && BIT_ADDR_OUT == $past(BIT_ADDR_IN, 2)) else $error("carry store");
    a_and_or: assert property (ex && OP_CODE_IN inside {4'h3, 4'h4} |=> CARRY_OUT ==
        ($past(OP_CODE_IN[0]) ? $past(CARRY_OUT) & $past(sb) : $past(CARRY_OUT) | $past(sb)))
        else $error("and or carry");
    a_carry_jump: assert property (tk && OP_CODE_IN inside {4'h5, 4'h6} |=> BUSY_OUT ##1
        DONE_OUT && JUMP_OUT == ($past(CARRY_OUT, 2) ~^ $past(OP_CODE_IN[0], 2)))
        else $error("carry jump");
    a_bit_jump: assert property (ex && OP_CODE_IN inside {4'h7, 4'h8} |-> ##2
        DONE_OUT && JUMP_OUT == ($past(BIT_RDATA_IN, 2) ~^ $past(OP_CODE_IN[0], 2)))
        else $error("bit jump");
    a_clear_taken: assert property (ex && OP_CODE_IN == 4'h9 |-> ##2 JUMP_OUT ==
        $past(BIT_RDATA_IN, 2) && BIT_WE_OUT == JUMP_OUT && (!BIT_WE_OUT || !BIT_WDATA_OUT))
        else $error("jump and clear");
    a_jump_target: assert property (tk && OP_CODE_IN inside {[4'h5:4'hA]} |-> ##2
        !JUMP_OUT || JUMP_TARGET_OUT == $past(PC_NEXT_IN, 2)
        + {{8{$past(DISP_IN[7], 2)}}, $past(DISP_IN, 2)}) else $error("jump target");
    a_alu_carry: assert property (ALU_C_WE_IN && !OP_VALID_IN && !BUSY_OUT |=>
        CARRY_OUT == $past(ALU_C_IN)) else $error("alu carry");
endmodule
bind bool_bit_proc bool_bit_chk i_chk (.MCLK_IN, .RST_IN, .OP_VALID_IN, .BIT_INV_IN,
    .BIT_RDATA_IN, .ALU_C_WE_IN, .ALU_C_IN, .BIT_WE_OUT, .BIT_WDATA_OUT, .JUMP_OUT,
    .DONE_OUT, .BUSY_OUT, .CARRY_OUT, .OP_CODE_IN, .BIT_ADDR_IN, .DISP_IN, .BIT_ADDR_OUT,
    .PC_NEXT_IN, .JUMP_TARGET_OUT);

// file: tb/bit_store_model.sv
/* Bit store on the far side: 256 bits, combinational read.
   Assumes one-cycle write strobes on the core clock. */
module bit_store_model (
    input  logic       clk_in,
    input  logic [7:0] raddr_in,
    input  logic       we_in,
    input  logic [7:0] waddr_in,
    input  logic       wdata_in,
    output logic       rdata_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic mem [0:255]; // Preloaded by the bench
    // Forward a pending write so a back-to-back read is not stale
    assign rdata_out = (we_in && waddr_in == raddr_in) ? wdata_in : mem[raddr_in];
    always @(posedge clk_in) if (we_in) mem[waddr_in] <= wdata_in;
endmodule

// file: tb/tb_top.sv
/* Bench for the Boolean bit datapath with a reference model.
   Assumes the bit store model and the bound checker. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // Stimulus, model state and counters
    logic MCLK_IN = 0, RST_IN = 1, OP_VALID_IN = 0, BIT_INV_IN = 0, ALU_C_WE_IN = 0, ALU_C_IN = 0;
    logic [3:0]  OP_CODE_IN = 4'h0;
    logic [7:0]  BIT_ADDR_IN = 8'h00, DISP_IN = 8'h00, st = 8'h00;
    logic [15:0] PC_NEXT_IN = 16'h0000;
    wire  BIT_RDATA_IN, BIT_WE_OUT, BIT_WDATA_OUT, JUMP_OUT, DONE_OUT, BUSY_OUT, CARRY_OUT;
    wire  [7:0]  BIT_ADDR_OUT, STATUS_OUT;
    wire  [15:0] JUMP_TARGET_OUT;
    logic m [0:255]; // Mirror of the bit store
    int   bad_count = 0, n_tests = 0;
    always #10 MCLK_IN = ~MCLK_IN;
    bool_bit_proc i_dut (.MCLK_IN, .RST_IN, .OP_VALID_IN, .OP_CODE_IN, .BIT_ADDR_IN,
        .BIT_INV_IN, .DISP_IN, .PC_NEXT_IN, .BIT_RDATA_IN, .ALU_C_WE_IN, .ALU_C_IN,
        .BIT_ADDR_OUT, .BIT_WE_OUT, .BIT_WDATA_OUT, .JUMP_OUT, .JUMP_TARGET_OUT,
        .DONE_OUT, .BUSY_OUT, .CARRY_OUT, .STATUS_OUT);
    bit_store_model i_mem (.clk_in(MCLK_IN), .raddr_in(BIT_ADDR_IN), .we_in(BIT_WE_OUT),
        .waddr_in(BIT_ADDR_OUT), .wdata_in(BIT_WDATA_OUT), .rdata_out(BIT_RDATA_IN));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        n_tests++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One operation: model first, then drive and compare at completion
    task automatic op(input logic [3:0] c, input logic [7:0] a,
                      input logic v, input logic [7:0] d);
        logic b, tk, wr, wv, ex;
        logic [15:0] pc;
        int n;
        pc = 16'($urandom);
        ex = a[7:3] != 5'h1A;
        b = ex ? m[a] : st[a[2:0]];
        {tk, wr, wv, n} = 0;
        case (c)
            4'h1: st[7] = b;
            4'h2: {wr, wv} = {1'b1, st[7]};
            4'h3: st[7] = st[7] & (b ^ v);
            4'h4: st[7] = st[7] | (b ^ v);
            4'h5, 4'h6: tk = st[7] ~^ c[0];
            4'h7, 4'h8: tk = b ~^ c[0];
            4'h9: {tk, wr} = {b, b};
            4'hA: tk = 1;
            4'hB, 4'hC: st[7] = c[0];
            4'hD, 4'hE: {wr, wv} = {1'b1, c[0]};
            default: ;
        endcase
        if (wr && ex) m[a] = wv;
        else if (wr) st[a[2:0]] = wv;
        @(negedge MCLK_IN);
        {OP_VALID_IN, OP_CODE_IN, BIT_ADDR_IN} = {1'b1, c, a};
        {BIT_INV_IN, DISP_IN, PC_NEXT_IN} = {v, d, pc};
        do begin
            @(negedge MCLK_IN);
            OP_VALID_IN = 0;
            n++;
        end while (DONE_OUT !== 1'b1 && n < 6);
        chk("cycles", (c == 4'h2 || (c > 4'h4 && c < 4'hB)) ? 16'h2 : 16'h1, 16'(n));
        chk("jump", tk, JUMP_OUT);
        if (tk) chk("target", pc + {{8{d[7]}}, d}, JUMP_TARGET_OUT);
        chk("write", wr && ex, BIT_WE_OUT);
        if (wr && ex) chk("wdata", {a, wv}, {BIT_ADDR_OUT, BIT_WDATA_OUT});
        chk("status", st, STATUS_OUT);
    endtask
    task automatic alu(input logic v);
        @(negedge MCLK_IN);
        {ALU_C_WE_IN, ALU_C_IN} = {1'b1, v};
        @(negedge MCLK_IN);
        ALU_C_WE_IN = 0;
        st[7] = v;
        chk("alu carry", v, CARRY_OUT);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #200000;
        bad_count++;
        finish_test;
    end
    initial begin
        void'($urandom(37));
        for (int i = 0; i < 256; i++) begin
            m[i] = 1'($urandom);
            i_mem.mem[i] = m[i];
        end
        repeat (20) @(negedge MCLK_IN);
        RST_IN = 0;
        chk("reset", 16'h0000, {CARRY_OUT, STATUS_OUT});
        op(4'hD, 8'hD5, 0, 8'h00);
        op(4'hE, 8'hD5, 0, 8'h00);
        for (int c = 0; c < 15; c++) op(4'(c), 8'($urandom), 1'($urandom), 8'($urandom));
        op(4'hA, 8'h00, 0, 8'h80);
        op(4'hA, 8'h00, 0, 8'h7F);
        op(4'hA, 8'h00, 0, 8'h00);
        op(4'hD, 8'h20, 0, 8'h05);
        op(4'h9, 8'h20, 0, 8'hF0);
        op(4'h9, 8'h20, 0, 8'hF0);
        repeat (300) begin
            op(4'($urandom_range(0, 14)), 8'($urandom), 1'($urandom), 8'($urandom));
            if ($urandom_range(0, 3) == 0) alu(1'($urandom));
        end
        finish_test;
    end
endmodule
